// [hw/ucf_map.svh]
// Purpose: named constants of the clock and frame formatter
// Assumes: included by the buffer and top design files of the block; the package does not include it
// Notes: definitions only
//
// Notes on behaviour
// - five clock modes: async normal, async double, sync master, slave, SPI
// - internal generator everywhere except sync slave, which uses the pin
// - period setting is unsigned twelve bits, 0 through 4095
// - signed scale -7..+7 trims the generated rate fractionally
// - async normal: clock over 2^s*16*(p+1), or 16*(2^s*p+1) when s<0
// - double speed uses eight in place of sixteen
// - sync master and SPI bit clock is clock over 2*(p+1)
// - double speed takes eight samples per bit instead of sixteen
// - slave clock sampled by system clock; partner keeps it below quarter
// - clock pin driven in master modes, released in slave mode
// - receive sampled on edge opposite to transmit change; invert swaps
// - SPI master uses only the internal clock, sync master rate
// - invert and phase select SPI modes 0 to 3
// - frames of 5..9 data bits, none/even/odd parity, one or two stops
// - low start, data lsb first, optional parity, high stops
// - next start follows the stops directly or the line idles high
// - even parity is one for odd ones count; odd parity the reverse
// - SPI frames are eight bits, msb or lsb first
`ifndef UCF_MAP_SVH
`define UCF_MAP_SVH
`define UCF_OVS_NORMAL 5'h10
`define UCF_OVS_DOUBLE 5'h08
`define UCF_SPI_BITS   4'h8
`define UCF_DATA_MIN   4'h5
`define UCF_DATA_MAX   4'h9
`define UCF_PAR_NONE   2'h0
`define UCF_PAR_EVEN   2'h1
`define UCF_PAR_ODD    2'h2
`define UCF_LINE_IDLE  1'b1
`define UCF_LINE_START 1'b0
`define UCF_ACC_W      7
`define UCF_FRAME_W    13
`define UCF_BUF_DEPTH  2
`endif

// [hw/ucf_pkg.sv]
// Purpose: shared types of the clock and frame formatter
// Assumes: nothing
// Notes: mode codes are the values of the mode port
package ucf_pkg;
	// =====================================================
	// clock modes; double speed is a separate select
	typedef enum logic [1:0] {
		UCF_ASYNC,
		UCF_SYNC_MASTER,
		UCF_SYNC_SLAVE,
		UCF_SPI_MASTER
	} ucf_mode_t;
	// frame shifter states
	typedef enum logic {
		UCF_ST_IDLE,
		UCF_ST_SHIFT
	} ucf_state_t;
endpackage

// [hw/ucf_buf.sv]
// Purpose: two-entry valid/ready buffer in the transmit data path
// Assumes: one clock, async active-low reset
// Notes: all outputs are registered
`timescale 1ns/100ps
`include "ucf_map.svh"
module ucf_buf #(
	parameter int W     = 9,
	parameter int DEPTH = `UCF_BUF_DEPTH
) (
	input  wire logic         sys_clk_i,   // system clock
	input  wire logic         nrst_i,      // async reset, low
	input  wire logic         clk_en_i,    // freezes state when low
	input  wire logic         in_valid_i,  // word offered
	input  wire logic [W-1:0] in_data_i,   // offered word
	output logic              in_ready_o,  // room for a word
	output logic              out_valid_o, // head word present
	output logic [W-1:0]      out_data_o,  // head word
	input  wire logic         out_ready_i  // head word taken
);
	// =====================================================
	// structure check
	if (DEPTH != 2 || W < 1) begin : g_bad
		$error("ucf_buf serves exactly two entries");
	end
	typedef struct packed {
		logic [W-1:0] e0;
		logic [W-1:0] e1;
		logic [1:0]   cnt;
		logic         rdy;
		logic         vld;
	} ucf_buf_t;
	localparam ucf_buf_t RST = '{e0: '0, e1: '0, cnt: 2'h0,
		rdy: 1'b1, vld: 1'b0};
	ucf_buf_t s, next_s;
	logic     push, pop;
	// =====================================================
	// pop shifts the tail forward; push fills the first free slot
	always_comb begin
		next_s = s;
		push = in_valid_i & s.rdy;
		pop = out_ready_i & s.vld;
		if (pop) begin
			next_s.e0 = s.e1;
			next_s.cnt = s.cnt - 2'h1;
		end
		if (push) begin
			if (next_s.cnt == 2'h0) begin
				next_s.e0 = in_data_i;
			end else begin
				next_s.e1 = in_data_i;
			end
			next_s.cnt = next_s.cnt + 2'h1;
		end
		next_s.rdy = (next_s.cnt != 2'h2); // full stalls the source
		next_s.vld = (next_s.cnt != 2'h0);
	end
	// state register
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= RST;
		end else if (clk_en_i) begin
			s <= next_s;
		end
	end
	assign in_ready_o = s.rdy;
	assign out_valid_o = s.vld;
	assign out_data_o = s.e0;
endmodule // ucf_buf

// [hw/ucf_top.sv]
// Purpose: baud generation, transfer clock and frame shifting
// Assumes: settings held stable while busy; one 25 MHz system clock
// Notes: async reception recovery lives outside; this block gives it ticks
`timescale 1ns/100ps
`include "ucf_map.svh"
module ucf_top
	import ucf_pkg::*;
#(
	parameter int PERIOD_W = 12,
	parameter int DATA_W   = 9
) (
	input  wire logic                sys_clk_i,                // 25 MHz
	input  wire logic                nrst_i,                   // async, low
	input  wire logic                clk_en_i,                 // freeze
	input  wire ucf_mode_t           mode_i,                   // clock mode
	input  wire logic                double_speed_select_i,    // async x2
	input  wire logic [PERIOD_W-1:0] baud_period_setting_i,    // period
	input  wire logic signed [3:0]   baud_scale_exponent_i,    // -7..+7
	input  wire logic                pin_invert_setting_i,     // edge swap
	input  wire logic                spi_clock_phase_i,        // SPI phase
	input  wire logic                spi_lsb_first_i,          // SPI order
	input  wire logic [3:0]          data_bits_i,              // 5..9
	input  wire logic [1:0]          parity_mode_i,            // none/ev/odd
	input  wire logic                two_stop_i,               // two stops
	input  wire logic                tx_valid_i,               // word offered
	input  wire logic [DATA_W-1:0]   tx_data_i,                // word
	output logic                     tx_ready_o,               // buffer room
	input  wire logic                rx_data_pin_i,            // serial in
	input  wire logic                transfer_clock_pin_i,     // clock pin in
	output logic                     transfer_clock_o,         // clock pin out
	output logic                     transfer_clock_oe_n_o,    // low: drive
	output logic                     tx_pin_o,                 // serial out
	output logic                     sample_tick_o,            // oversample
	output logic                     baud_tick_o,              // bit pulse
	output logic                     rx_sample_o,              // bit strobe
	output logic                     rx_bit_o,                 // sampled bit
	output logic [7:0]               rx_data_o,                // SPI word
	output logic                     rx_valid_o,               // word pulse
	output logic                     busy_o                    // in frame
);
	// =====================================================
	// parameter checks
	localparam int CNT_W = PERIOD_W + 7;
	localparam int FW = `UCF_FRAME_W;
	if (PERIOD_W < 12 || PERIOD_W > 16 || DATA_W != 9) begin : g_bad
		$error("ucf_top needs a 12..16 bit period and 9-bit data");
	end

	typedef struct packed {
		logic                  xs1, xs2, xprev; // clock pin sync
		logic                  rs1, rs2;        // data pin sync
		ucf_state_t            st;
		logic [CNT_W-1:0]      cnt;
		logic [`UCF_ACC_W-1:0] acc;
		logic [4:0]            ovs;
		logic                  ck, first;
		logic [3:0]            nleft;
		logic [FW-1:0]         frame;
		logic [7:0]            rxw;
		logic                  txd, transfer_clock_pin, xck_oe_n;
		logic                  btick, stick, rsmp, rbit;
		logic [7:0]            rdata;
		logic                  rvld, busy;
	} ucf_core_t;
	localparam ucf_core_t RST = '{st: UCF_ST_IDLE, frame: '1,
		txd: `UCF_LINE_IDLE, xck_oe_n: 1'b1, default: '0};

	ucf_core_t         s, next_s;
	logic              buf_valid, ld, done, tick, bit_tick;
	logic [DATA_W-1:0] buf_data;

	// =====================================================
	// functions
	// gap to the next oversample tick as {acc, count}
	function automatic logic [CNT_W+`UCF_ACC_W-1:0] f_reload(
		input logic [PERIOD_W-1:0]   per,
		input logic signed [3:0]     sc,
		input logic [`UCF_ACC_W-1:0] acc);
		logic [CNT_W-1:0]      sum;
		logic [CNT_W-1:0]      c;
		logic [`UCF_ACC_W-1:0] a;
		logic [3:0]            mag;
		sum = '0;
		mag = 4'(-sc);
		if (sc >= 0) begin
			c = (CNT_W'(per) + CNT_W'(1)) << sc[2:0];
			c = c - CNT_W'(1);
			a = acc;
		end else begin
			// fraction accumulates so gaps average 1 + p/2^k
			sum = CNT_W'(per) + CNT_W'(acc);
			c = sum >> mag[2:0];
			a = sum[`UCF_ACC_W-1:0] & ~(7'h7f << mag[2:0]);
		end
		return {a, c};
	endfunction

	// even parity is one when the ones count is odd
	function automatic logic f_parity(input logic [8:0] d,
		input logic [3:0] nb, input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++) begin
			if (i < nb) begin
				p = p ^ d[i];
			end
		end
		return p;
	endfunction

	// =====================================================
	// load values for the next frame
	logic [3:0]    nb, ld_len;
	logic [FW-1:0] ld_frame;
	logic          master, slave, async_m, spi;
	always_comb begin
		master = (mode_i == UCF_SYNC_MASTER) || (mode_i == UCF_SPI_MASTER);
		slave = (mode_i == UCF_SYNC_SLAVE);
		async_m = (mode_i == UCF_ASYNC);
		spi = (mode_i == UCF_SPI_MASTER);
		// out of range widths are clamped, not rejected
		nb = data_bits_i;
		if (data_bits_i < `UCF_DATA_MIN) begin
			nb = `UCF_DATA_MIN;
		end else if (data_bits_i > `UCF_DATA_MAX) begin
			nb = `UCF_DATA_MAX;
		end
		ld_frame = '1; // stop bits are the ones left over
		if (spi) begin
			for (int i = 0; i < 8; i++) begin
				ld_frame[i] = spi_lsb_first_i ? buf_data[i] : buf_data[7-i];
			end
			ld_len = `UCF_SPI_BITS;
		end else begin
			ld_frame[0] = `UCF_LINE_START;
			for (int i = 0; i < 9; i++) begin
				if (i < nb) begin
					ld_frame[i+1] = buf_data[i];
				end
			end
			if (parity_mode_i != `UCF_PAR_NONE) begin
				ld_frame[nb+4'h1] = f_parity(buf_data, nb,
					parity_mode_i == `UCF_PAR_ODD);
			end
			ld_len = 4'h1 + nb + 4'((parity_mode_i != `UCF_PAR_NONE))
				+ (two_stop_i ? 4'h2 : 4'h1);
		end
	end

	// =====================================================
	// generator, edges and shifter
	logic [CNT_W+`UCF_ACC_W-1:0] rl;
	logic [4:0] ovs_lim;
	logic lead, trail, setup_lead, ms_setup, ms_sample;
	logic rise, fall, sl_setup, sl_sample, step, smp;
	always_comb begin
		next_s = s;
		next_s.stick = 1'b0;
		next_s.rsmp = 1'b0;
		next_s.rvld = 1'b0;
		// two-stage synchronisers, edges from stage two only
		next_s.xs1 = transfer_clock_pin_i;
		next_s.xs2 = s.xs1;
		next_s.xprev = s.xs2;
		next_s.rs1 = rx_data_pin_i;
		next_s.rs2 = s.rs1;
		rise = s.xs2 & ~s.xprev;
		fall = ~s.xs2 & s.xprev;
		// divider: masters count p+1 per half period
		tick = (s.cnt == '0);
		rl = f_reload(baud_period_setting_i, baud_scale_exponent_i, s.acc);
		if (tick) begin
			next_s.cnt = master ? CNT_W'(baud_period_setting_i)
				: rl[CNT_W-1:0];
			next_s.acc = master ? s.acc : rl[CNT_W +: `UCF_ACC_W];
			next_s.stick = ~master;
		end else begin
			next_s.cnt = s.cnt - CNT_W'(1);
		end
		// sixteen or eight samples per bit
		ovs_lim = double_speed_select_i ? `UCF_OVS_DOUBLE : `UCF_OVS_NORMAL;
		bit_tick = 1'b0;
		if (tick && !master) begin
			if (s.ovs >= ovs_lim - 5'h01) begin
				next_s.ovs = 5'h00;
				bit_tick = 1'b1;
			end else begin
				next_s.ovs = s.ovs + 5'h01;
			end
		end
		// master edges: leading leaves the idle level
		lead = master && tick && (s.st == UCF_ST_SHIFT) && !s.ck;
		trail = master && tick && (s.st == UCF_ST_SHIFT) && s.ck;
		if (lead || trail) begin
			next_s.ck = ~s.ck;
		end
		// sync master always sets up on leading edge
		setup_lead = !spi || spi_clock_phase_i;
		ms_setup = setup_lead ? lead : trail;
		ms_sample = setup_lead ? trail : lead;
		sl_setup = slave && (pin_invert_setting_i ? fall : rise);
		sl_sample = slave && (pin_invert_setting_i ? rise : fall);
		step = (async_m && bit_tick) || sl_setup;
		smp = ms_sample || sl_sample;
		if (smp) begin
			next_s.rsmp = 1'b1;
			next_s.rbit = s.rs2;
			next_s.rxw = spi_lsb_first_i ? {s.rs2, s.rxw[7:1]}
				: {s.rxw[6:0], s.rs2};
		end
		ld = 1'b0;
		done = 1'b0;
		unique case (s.st)
			UCF_ST_IDLE: begin
				// a slave only starts on a setup edge of the pin clock
				ld = buf_valid && (!slave || sl_setup);
			end
			UCF_ST_SHIFT: begin
				if (master) begin
					if (ms_setup) begin
						next_s.first = 1'b0;
						// a leading setup edge finds bit 0 already shown;
						// a trailing one must move on or bit 0 is sent twice
						if (!(s.first && setup_lead)) begin
							next_s.frame = {1'b1, s.frame[FW-1:1]};
						end
					end
					if (trail) begin
						if (s.nleft == 4'h1) begin
							done = 1'b1;
						end else begin
							next_s.nleft = s.nleft - 4'h1;
						end
					end
				end else if (step) begin
					if (s.nleft == 4'h1) begin
						done = 1'b1;
					end else begin
						next_s.frame = {1'b1, s.frame[FW-1:1]};
						next_s.nleft = s.nleft - 4'h1;
					end
				end
				// next start directly after the stops, else idle
				ld = done && buf_valid;
				if (done && !buf_valid) begin
					next_s.st = UCF_ST_IDLE;
					next_s.frame = '1;
				end
			end
		endcase
		if (done && spi) begin
			next_s.rdata = next_s.rxw;
			next_s.rvld = 1'b1;
		end
		if (ld) begin
			next_s.st = UCF_ST_SHIFT;
			next_s.frame = ld_frame;
			next_s.nleft = ld_len;
			next_s.first = 1'b1;
			// restart timing so the first bit has full length
			if (s.st == UCF_ST_IDLE) begin
				next_s.ovs = 5'h00;
				next_s.ck = 1'b0;
				next_s.cnt = master ? CNT_W'(baud_period_setting_i)
					: rl[CNT_W-1:0];
				// the fraction advances with the gap it produced
				next_s.acc = master ? s.acc
					: rl[CNT_W +: `UCF_ACC_W];
			end
		end
		next_s.btick = (async_m && bit_tick) || trail || sl_setup;
		next_s.txd = (next_s.st == UCF_ST_SHIFT) ? next_s.frame[0]
			: `UCF_LINE_IDLE;
		// pin driven only by masters; invert moves the idle level
		next_s.transfer_clock_pin = (master & next_s.ck) ^ pin_invert_setting_i;
		next_s.xck_oe_n = ~master;
		next_s.busy = (next_s.st == UCF_ST_SHIFT);
	end

	// state register; clock enable freezes everything
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= RST;
		end else if (clk_en_i) begin
			s <= next_s;
		end
	end

	// =====================================================
	// transmit buffer, drained by frame loads
	ucf_buf #(.W(DATA_W), .DEPTH(`UCF_BUF_DEPTH)) u_buf (
		.sys_clk_i   (sys_clk_i),
		.nrst_i      (nrst_i),
		.clk_en_i    (clk_en_i),
		.in_valid_i  (tx_valid_i),
		.in_data_i   (tx_data_i),
		.in_ready_o  (tx_ready_o),
		.out_valid_o (buf_valid),
		.out_data_o  (buf_data),
		.out_ready_i (ld)
	);

	// outputs straight from the state register
	assign transfer_clock_o = s.transfer_clock_pin;
	assign transfer_clock_oe_n_o = s.xck_oe_n;
	assign tx_pin_o = s.txd;
	assign sample_tick_o = s.stick;
	assign baud_tick_o = s.btick;
	assign rx_sample_o = s.rsmp;
	assign rx_bit_o = s.rbit;
	assign rx_data_o = s.rdata;
	assign rx_valid_o = s.rvld;
	assign busy_o = s.busy;

	// =====================================================
	// checks
	a_idle_line_high: assert property (@(posedge sys_clk_i)
		disable iff (!nrst_i) !busy_o |-> tx_pin_o)
		else $error("line not high while idle");
	a_start_bit_low: assert property (@(posedge sys_clk_i)
		disable iff (!nrst_i)
		(clk_en_i && ld && s.st == UCF_ST_IDLE && !spi) |=> !tx_pin_o)
		else $error("frame did not open with a low start bit");
	a_spi_eight_bits: assert property (@(posedge sys_clk_i)
		disable iff (!nrst_i) (clk_en_i && ld && spi) |=> s.nleft == 4'h8)
		else $error("SPI frame not eight bits");
	a_even_parity: assert property (@(posedge sys_clk_i)
		disable iff (!nrst_i) (clk_en_i && ld && !spi && data_bits_i == 4'h8
		&& parity_mode_i == `UCF_PAR_EVEN)
		|=> s.frame[9] == ^($past(buf_data[7:0])))
		else $error("even parity bit wrong");
	a_master_drives: assert property (@(posedge sys_clk_i)
		disable iff (!nrst_i) (clk_en_i && master)
		|=> !transfer_clock_oe_n_o)
		else $error("master does not drive the clock pin");
	a_slave_release: assert property (@(posedge sys_clk_i)
		disable iff (!nrst_i) (clk_en_i && slave) |=> transfer_clock_oe_n_o)
		else $error("slave drives the clock pin");
	a_half_period: assert property (@(posedge sys_clk_i)
		disable iff (!nrst_i) (clk_en_i && master && s.cnt == '0)
		|=> s.cnt == CNT_W'($past(baud_period_setting_i)))
		else $error("master half period not p+1 cycles");
	a_slave_edge_only: assert property (@(posedge sys_clk_i)
		disable iff (!nrst_i) (clk_en_i && slave && s.st == UCF_ST_SHIFT
		&& s.xs2 == s.xprev) |=> s.nleft == $past(s.nleft))
		else $error("slave shifted without a pin edge");
	a_spi_idle_clock: assert property (@(posedge sys_clk_i)
		disable iff (!nrst_i) (clk_en_i && spi && s.st == UCF_ST_IDLE && !ld)
		|=> transfer_clock_o == $past(pin_invert_setting_i))
		else $error("SPI clock not at idle level");
	a_async_sample: assert property (@(posedge sys_clk_i)
		disable iff (!nrst_i) (clk_en_i && async_m && s.cnt == '0)
		|=> sample_tick_o)
		else $error("oversample tick missing");
endmodule // ucf_top

// [verif/ucf_partner.sv]
// ============================================================
// Purpose: far-side model of the clock and frame formatter
// Assumes: shares the 25 MHz system clock with the block
// Notes: async frame receiver, slave clock source, data echo
`timescale 1ns/100ps
module ucf_partner (
	input  wire logic sys_clk_i,  // system clock
	input  wire logic tx_pin_i,   // serial line from the block
	input  wire logic loop_en_i,  // echo the line back
	input  wire logic idle_lvl_i, // rest level of slave clock
	output logic      rx_pin_o,   // serial line to the block
	output logic      xclk_o      // slave transfer clock
);
	// a silent line rests high, as an idle async line does
	assign rx_pin_o = loop_en_i ? tx_pin_i : 1'b1;
	initial xclk_o = 1'b0;

	// ============================================================
	// async receiver, samples each bit at its middle
	task automatic rx_frame(input int bt, input int nb, input logic par,
		input logic two, output logic [8:0] d, output logic [2:0] tail,
		output int waited);
		waited = 0;
		d = '0;
		tail = 3'h6;
		while (tx_pin_i !== 1'b0 && waited < 20000) begin
			@(posedge sys_clk_i);
			waited++;
		end
		repeat (bt / 2) @(posedge sys_clk_i);
		for (int i = 0; i < nb; i++) begin
			repeat (bt) @(posedge sys_clk_i);
			d[i] = tx_pin_i;
		end
		if (par) begin
			repeat (bt) @(posedge sys_clk_i);
			tail[0] = tx_pin_i;
		end
		repeat (bt) @(posedge sys_clk_i);
		tail[1] = tx_pin_i;
		if (two) begin
			repeat (bt) @(posedge sys_clk_i);
			tail[2] = tx_pin_i;
		end
	endtask

	// ============================================================
	// slave clock: runs only inside this call, rests otherwise;
	// half of 4 cycles keeps each phase sampled twice or more
	task automatic slave_clocks(input int n, input int half,
		output logic [15:0] bits);
		bits = '0;
		for (int i = 0; i < n; i++) begin
			repeat (half) @(posedge sys_clk_i);
			#1 xclk_o = ~idle_lvl_i;
			repeat (half) @(posedge sys_clk_i);
			#1 xclk_o = idle_lvl_i;
			bits[i] = tx_pin_i;
		end
	endtask
endmodule // ucf_partner

// [verif/test_ucf_top.sv]
// ============================================================
// Purpose: self-checking bench for the clock and frame formatter
// Assumes: 25 MHz clock, active-low reset held for 12 cycles
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/100ps
`define UCF_CHK(what, exp, got) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) begin \
			n_mismatch++; \
			$display("mismatch %s expected %0h seen %0h", what, exp, got); \
		end \
	end
module test_ucf_top
	import ucf_pkg::*;
;
	localparam int LIM = 20000; // bound of every wait
	localparam int DB_T[5]  = '{0, 1, 0, 0, 1};
	localparam int PER_T[5] = '{0, 2, 1, 6, 0};
	localparam int SC_T[5]  = '{0, 0, 2, -2, 0};
	localparam int BIT_T[5] = '{16, 24, 128, 40, 8};
	localparam int OVS_T[5] = '{16, 8, 16, 16, 8};
	localparam int NB_T[5]  = '{5, 9, 7, 8, 6};
	localparam int PAR_T[5] = '{1, 2, 0, 1, 3};
	localparam int TWO_T[5] = '{0, 1, 1, 0, 1};
	logic sys_clk_i = 1'b0, nrst_i, clk_en_i, double_speed_select_i;
	logic pin_invert_setting_i, spi_clock_phase_i, spi_lsb_first_i;
	logic two_stop_i, tx_valid_i, tx_ready_o, rx_data_pin_i, loop_en;
	logic transfer_clock_pin_i, transfer_clock_o, transfer_clock_oe_n_o;
	logic tx_pin_o, sample_tick_o, baud_tick_o, rx_sample_o, rx_bit_o;
	logic rx_valid_o, busy_o, lvl_q;
	ucf_mode_t         mode_i;
	logic [11:0]       baud_period_setting_i;
	logic signed [3:0] baud_scale_exponent_i;
	logic [3:0]        data_bits_i;
	logic [1:0]        parity_mode_i;
	logic [8:0]        tx_data_i;
	logic [7:0]        rx_data_o;
	int n_mismatch = 0, num_checks = 0, cyc = 0, n_lead = 0, n_tick = 0;
	int t_first, t_second, n_smp, n_btk;

	always #20 sys_clk_i = ~sys_clk_i;

	ucf_top dut_u (.sys_clk_i, .nrst_i, .clk_en_i, .mode_i,
		.double_speed_select_i, .baud_period_setting_i,
		.baud_scale_exponent_i, .pin_invert_setting_i, .spi_clock_phase_i,
		.spi_lsb_first_i, .data_bits_i, .parity_mode_i, .two_stop_i,
		.tx_valid_i, .tx_data_i, .tx_ready_o, .rx_data_pin_i,
		.transfer_clock_pin_i, .transfer_clock_o, .transfer_clock_oe_n_o,
		.tx_pin_o, .sample_tick_o, .baud_tick_o, .rx_sample_o, .rx_bit_o,
		.rx_data_o, .rx_valid_o, .busy_o);

	ucf_partner partner_u (.sys_clk_i, .tx_pin_i(tx_pin_o),
		.loop_en_i(loop_en), .idle_lvl_i(pin_invert_setting_i),
		.rx_pin_o(rx_data_pin_i), .xclk_o(transfer_clock_pin_i));

	// ============================================================
	// monitor: leading edges of the driven clock, oversample ticks
	always @(posedge sys_clk_i) begin
		cyc++;
		if (lvl_q === pin_invert_setting_i &&
			transfer_clock_o === ~pin_invert_setting_i) begin
			n_lead++;
			if (n_lead == 1) t_first = cyc;
			if (n_lead == 2) t_second = cyc;
		end
		lvl_q = transfer_clock_o;
		if (sample_tick_o === 1'b1) n_tick++;
		if (rx_sample_o === 1'b1) n_smp++;
		if (baud_tick_o === 1'b1) n_btk++;
	end

	// ============================================================
	// helpers
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) begin
			@(posedge sys_clk_i);
			#1;
		end
	endtask

	task automatic stall_check(input int w);
		if (w >= LIM) begin
			n_mismatch++;
			$display("mismatch wait bound expected done seen stuck");
			complete_run();
		end
	endtask

	// words are held until taken; valid drops only after the last
	task automatic put_words(input logic [8:0] q[$]);
		logic rdy;
		int w;
		tx_valid_i = 1'b1;
		foreach (q[i]) begin
			tx_data_i = q[i];
			w = 0;
			do begin
				rdy = tx_ready_o;
				step(1);
				w++;
			end while (!rdy && w < LIM);
			stall_check(w);
		end
		tx_valid_i = 1'b0;
	endtask

	task automatic wait_idle();
		int w;
		w = 0;
		step(3);
		while (busy_o !== 1'b0 && w < LIM) begin
			step(1);
			w++;
		end
		stall_check(w);
	endtask

	// width of the low run of an all-zero frame, and ticks inside it
	task automatic measure_low(output int lo, output int tk);
		int w;
		int t0;
		w = 0;
		lo = 0;
		while (tx_pin_o !== 1'b0 && w < LIM) begin
			step(1);
			w++;
		end
		stall_check(w);
		// ticks raised inside the span: drop the one showing now,
		// add the one raised by the last low cycle
		t0 = n_tick + int'(sample_tick_o === 1'b1);
		while (tx_pin_o === 1'b0 && lo < LIM) begin
			step(1);
			lo++;
		end
		tk = n_tick - t0 + int'(sample_tick_o === 1'b1);
	endtask

	// ============================================================
	// main sequence
	initial begin
		logic [8:0] d, dm, rd;
		logic [2:0] tl, te;
		logic [15:0] bits;
		int lo, tk, w, k;
		nrst_i = 1'b0;
		clk_en_i = 1'b1;
		mode_i = UCF_ASYNC;
		double_speed_select_i = 1'b0;
		baud_period_setting_i = 12'h000;
		baud_scale_exponent_i = 4'h0;
		pin_invert_setting_i = 1'b0;
		spi_clock_phase_i = 1'b0;
		spi_lsb_first_i = 1'b0;
		data_bits_i = 4'h8;
		parity_mode_i = 2'h0;
		two_stop_i = 1'b0;
		tx_valid_i = 1'b0;
		tx_data_i = 9'h000;
		loop_en = 1'b0;
		step(12);
		`UCF_CHK("idle line", 1'b1, tx_pin_o)
		`UCF_CHK("pin released", 1'b1, transfer_clock_oe_n_o)
		`UCF_CHK("room", 1'b1, tx_ready_o)
		nrst_i = 1'b1;
		step(2);
		// rates: zero period always with zero scale, negative scale too
		for (int i = 0; i < 5; i++) begin
			double_speed_select_i = DB_T[i][0];
			baud_period_setting_i = 12'(PER_T[i]);
			baud_scale_exponent_i = 4'(SC_T[i]);
			step(2);
			fork
				put_words({9'h000});
				measure_low(lo, tk);
			join
			`UCF_CHK("low span", 9 * BIT_T[i], lo)
			`UCF_CHK("ticks", 9 * OVS_T[i], tk)
			wait_idle();
		end
		double_speed_select_i = 1'b0;
		baud_period_setting_i = 12'h000;
		baud_scale_exponent_i = 4'h0;
		// layouts: data count, parity code, stop count
		for (int i = 0; i < 5; i++) begin
			data_bits_i = 4'(NB_T[i]);
			parity_mode_i = 2'(PAR_T[i]);
			two_stop_i = TWO_T[i][0];
			d = 9'h1b3 ^ 9'(i * 37);
			dm = d & ((9'h001 << NB_T[i]) - 9'h001);
			step(2);
			fork
				put_words({d});
				partner_u.rx_frame(16, NB_T[i], PAR_T[i] != 0, TWO_T[i][0],
					rd, tl, w);
			join
			stall_check(w);
			`UCF_CHK("data", dm, rd)
			// code 2 is odd parity, 1 and 3 even, 0 none
			te = {2'h3, ^dm ^ (PAR_T[i] == 2)};
			if (PAR_T[i] == 0) te[0] = 1'b0;
			`UCF_CHK("tail", te, tl)
			wait_idle();
		end
		// stream: buffer fills and refuses, frames run back to back
		data_bits_i = 4'h8;
		parity_mode_i = 2'h0;
		two_stop_i = 1'b0;
		fork
			begin
				put_words({9'h031, 9'h062, 9'h0c4});
				`UCF_CHK("buffer full", 1'b0, tx_ready_o)
			end
			for (int j = 0; j < 3; j++) begin
				partner_u.rx_frame(16, 8, 1'b0, 1'b0, rd, tl, w);
				`UCF_CHK("stream data", 9'h031 << j, rd)
				if (j > 0) `UCF_CHK("no gap", 1'b1, w <= 10)
			end
		join
		wait_idle();
		`UCF_CHK("drained", 1'b1, tx_ready_o)
		// a frozen block neither takes the word nor starts a frame
		clk_en_i = 1'b0;
		put_words({9'h0ff});
		step(4);
		`UCF_CHK("frozen", 1'b0, busy_o)
		clk_en_i = 1'b1;
		// sync master, period setting 1: bit clock of four cycles
		mode_i = UCF_SYNC_MASTER;
		baud_period_setting_i = 12'h001;
		for (int v = 0; v < 2; v++) begin
			pin_invert_setting_i = v[0];
			step(4);
			n_lead = 0;
			put_words({9'h000});
			wait_idle();
			`UCF_CHK("drive pin", 1'b0, transfer_clock_oe_n_o)
			`UCF_CHK("bit period", 4, t_second - t_first)
			`UCF_CHK("bit count", 10, n_lead)
			`UCF_CHK("clock rest", v[0], transfer_clock_o)
		end
		// spi: four edge modes, both orders, data echoed back
		mode_i = UCF_SPI_MASTER;
		baud_period_setting_i = 12'h003;
		loop_en = 1'b1;
		for (int m = 0; m < 8; m++) begin
			pin_invert_setting_i = m[1];
			spi_clock_phase_i = m[0];
			spi_lsb_first_i = m[2];
			d = 9'(8'h1d + m * 8'h35);
			step(4);
			n_lead = 0;
			n_smp = 0;
			n_btk = 0;
			put_words({d});
			w = 0;
			while (rx_valid_o !== 1'b1 && w < LIM) begin
				step(1);
				w++;
			end
			stall_check(w);
			`UCF_CHK("spi echo", d[7:0], rx_data_o)
			wait_idle();
			`UCF_CHK("spi edges", 8, n_lead)
			`UCF_CHK("spi period", 8, t_second - t_first)
			`UCF_CHK("spi samples", 8, n_smp)
			`UCF_CHK("bit ticks", 8, n_btk)
			`UCF_CHK("last bit", m[2] ? d[7] : d[0], rx_bit_o)
		end
		loop_en = 1'b0;
		// sync slave: partner sources the clock, pin stays released
		mode_i = UCF_SYNC_SLAVE;
		pin_invert_setting_i = 1'b0;
		step(4);
		`UCF_CHK("slave pin", 1'b1, transfer_clock_oe_n_o)
		fork
			put_words({9'h05a});
			partner_u.slave_clocks(14, 4, bits);
		join
		k = 0;
		while (bits[k] !== 1'b0 && k < 4) k++;
		`UCF_CHK("slave data", 8'h5a, bits[k+8 -: 8])
		`UCF_CHK("slave stop", 1'b1, bits[k+9])
		complete_run();
	end
endmodule // test_ucf_top
